//--- src/clock_source_startup_select.sv
`timescale 1ns/100ps
// Behaviour
// - Crystal wake waits 1K or 32K cycles
// - Crystal reset delay 14CK plus fuse time
// - Fuse code 0010 selects internal RC
// - Divide-by-eight fuse divides core clock
// - Reset loads factory trim value
// - Software trim writes retune RC oscillator
// - Watchdog oscillator always times watchdog, time-out
// - RC wake 6 cycles, reset fuse delay
// - Shipped with RC source and code 10
// - Fuse code 0011 selects 128kHz oscillator
// - 128kHz wake 6, reset 4ms/64ms delay
module clock_source_startup_select
    import clock_startup_pkg::*;
#(
    parameter int CYC_DELAY_4P1MS = CYC_4P1MS,
    parameter int CYC_DELAY_65MS = CYC_65MS,
    parameter int CYC_DELAY_4MS = CYC_4MS,
    parameter int CYC_DELAY_64MS = CYC_64MS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] clockSourceSelectFuses,
    input wire logic startupLengthSelectFuse,
    input wire logic [1:0] startupTimeFuses,
    input wire logic divideByEightFuse,
    input wire logic [DATA_W-1:0] factoryTrim,
    input wire logic lfXtalTick,
    input wire logic rcTick,
    input wire logic lp128Tick,
    input wire logic watchdogTick,
    input wire logic sleepReq,
    input wire logic wakeReq,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    output logic [DATA_W-1:0] oscillatorTrimRegister,
    output logic [1:0] oscSelect,
    output logic clockGateOpen,
    output logic coreTick,
    output logic watchdogTickOut
);
    typedef struct packed {
        phase_t phase;
        osc_sel_t src;
        logic [3:0] srcFuse;
        logic [1:0] sutFuse;
        logic lenFuse;
        logic divFuse;
        logic [DATA_W-1:0] trim;
        logic [DATA_W-1:0] rdata;
        logic [2:0] divCnt;
        logic coreTick;
        logic wdtTick;
    } top_state_t;

    localparam top_state_t STATE_RESET = '{
        phase: PH_CAPTURE, src: OSC_RC, srcFuse: SRC_SHIPPED, sutFuse: SUT_SHIPPED,
        lenFuse: LEN_SHIPPED, divFuse: DIV8_SHIPPED, trim: TRIM_RESET,
        rdata: 8'h00, divCnt: 3'h0, coreTick: 1'b0, wdtTick: 1'b0};

    top_state_t st_r;
    top_state_t st_nxt;
    logic selTick;
    logic cntClear;
    logic cntAdvance;
    logic cntDone;
    logic [CNT_W-1:0] cntTarget;
    logic [CNT_W-1:0] resetDelay;

    // ==========================================
    // Reset delay decode
    function automatic logic [CNT_W-1:0] delayCycles(input osc_sel_t src, input logic [1:0] startup_time_fuses);
        delayCycles = '0;
        if (startup_time_fuses == SUT_FAST) begin
            delayCycles = (src == OSC_LP128) ? CNT_W'(CYC_DELAY_4MS) : CNT_W'(CYC_DELAY_4P1MS);
        end else if (startup_time_fuses == SUT_SLOW) begin
            delayCycles = (src == OSC_LP128) ? CNT_W'(CYC_DELAY_64MS) : CNT_W'(CYC_DELAY_65MS);
        end
    endfunction

    assign resetDelay = delayCycles(st_r.src, st_r.sutFuse);

    // ==========================================
    // Selected oscillator
    always_comb begin
        selTick = 1'b0;
        case (st_r.src)
            OSC_LFXTAL: selTick = lfXtalTick;
            OSC_RC: selTick = rcTick;
            OSC_LP128: selTick = lp128Tick;
            default: selTick = 1'b0;
        endcase
    end

    // ==========================================
    // Start-up counter control
    always_comb begin
        cntTarget = '0;
        cntAdvance = 1'b0;
        case (st_r.phase)
            PH_OSC14: begin
                cntTarget = RESET_OSC_CK;
                cntAdvance = selTick;
            end
            PH_DELAY: begin
                cntTarget = resetDelay;
                cntAdvance = watchdogTick;
            end
            PH_WAKE: begin
                cntTarget = wakeCycles(st_r.src, st_r.lenFuse);
                cntAdvance = selTick;
            end
            default: begin
                cntTarget = '0;
                cntAdvance = 1'b0;
            end
        endcase
    end

    assign cntClear = (st_nxt.phase != st_r.phase);

    osc_cycle_counter osc_cycle_counter_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clear(cntClear),
        .advance(cntAdvance),
        .target(cntTarget),
        .done(cntDone)
    );

    // ==========================================
    // Phase sequencing, trim and bus
    always_comb begin
        st_nxt = st_r;
        st_nxt.wdtTick = watchdogTick;
        st_nxt.coreTick = 1'b0;
        st_nxt.rdata = 8'h00;
        case (st_r.phase)
            PH_CAPTURE: begin
                st_nxt.srcFuse = clockSourceSelectFuses;
                st_nxt.sutFuse = startupTimeFuses;
                st_nxt.lenFuse = startupLengthSelectFuse;
                st_nxt.divFuse = divideByEightFuse;
                st_nxt.src = decodeSource(clockSourceSelectFuses);
                st_nxt.trim = factoryTrim;
                if (startupTimeFuses == SUT_RSVD || decodeSource(clockSourceSelectFuses) == OSC_NONE) begin
                    st_nxt.phase = PH_HALT;
                end else begin
                    st_nxt.phase = PH_OSC14;
                end
            end
            PH_OSC14: begin
                if (cntDone) begin
                    st_nxt.phase = (resetDelay == '0) ? PH_RUN : PH_DELAY;
                end
            end
            PH_DELAY: begin
                if (cntDone) begin
                    st_nxt.phase = PH_RUN;
                end
            end
            PH_RUN: begin
                if (selTick) begin
                    if (st_r.divFuse) begin
                        st_nxt.divCnt = st_r.divCnt + 3'h1;
                        st_nxt.coreTick = (st_r.divCnt == DIV8_LAST);
                    end else begin
                        st_nxt.coreTick = 1'b1;
                    end
                end
                if (sleepReq) begin
                    st_nxt.phase = PH_SLEEP;
                end
            end
            PH_SLEEP: begin
                if (wakeReq) begin
                    st_nxt.phase = PH_WAKE;
                end
            end
            PH_WAKE: begin
                if (cntDone) begin
                    st_nxt.phase = PH_RUN;
                end
            end
            default: begin
                st_nxt.phase = PH_HALT;
            end
        endcase
        if (regWr && regAddr == TRIM_ADDR && st_r.phase != PH_CAPTURE) begin
            st_nxt.trim = regWdata;
        end
        if (regRd) begin
            if (regAddr == TRIM_ADDR) begin
                st_nxt.rdata = st_r.trim;
            end else if (regAddr == STATUS_ADDR) begin
                st_nxt.rdata[STAT_RUN_BIT] = (st_r.phase == PH_RUN);
                st_nxt.rdata[STAT_HALT_BIT] = (st_r.phase == PH_HALT);
                st_nxt.rdata[STAT_SLEEP_BIT] = (st_r.phase == PH_SLEEP);
                st_nxt.rdata[STAT_DIV_BIT] = st_r.divFuse;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign regRdata = st_r.rdata;
    assign oscillatorTrimRegister = st_r.trim;
    assign oscSelect = st_r.src;
    assign clockGateOpen = (st_r.phase == PH_RUN);
    assign coreTick = st_r.coreTick;
    assign watchdogTickOut = st_r.wdtTick;

    // ==========================================
    // Checks
    gate_run_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clockGateOpen |-> $past(st_r.phase) != PH_SLEEP && st_r.phase == PH_RUN)
        else $error("Clock released outside run phase");
    reserved_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_CAPTURE && startupTimeFuses == SUT_RSVD ##1 st_r.phase != PH_CAPTURE
        |-> st_r.phase == PH_HALT ##1 !clockGateOpen)
        else $error("Reserved start-up code did not halt");
    trim_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_CAPTURE ##1 st_r.phase != PH_CAPTURE
        |-> oscillatorTrimRegister == $past(factoryTrim))
        else $error("Factory trim not loaded");
    trim_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWr && regAddr == TRIM_ADDR && st_r.phase != PH_CAPTURE |=> oscillatorTrimRegister == $past(regWdata))
        else $error("Trim write not applied");
    shipped_fuse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_CAPTURE |-> st_r.srcFuse == SRC_SHIPPED && st_r.sutFuse == SUT_SHIPPED)
        else $error("Shipped fuse defaults missing");
    source_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_CAPTURE && clockSourceSelectFuses == SRC_LP128 ##1 st_r.phase != PH_CAPTURE
        |-> oscSelect == OSC_LP128)
        else $error("Fuse source decode wrong");
    wake_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_WAKE && st_r.src != OSC_LFXTAL |-> cntTarget == WAKE_INT_CK)
        else $error("Internal oscillator wake count wrong");
    lf_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_WAKE && st_r.src == OSC_LFXTAL && st_r.lenFuse |-> cntTarget == WAKE_LF_LONG_CK)
        else $error("Crystal long wake count wrong");
    div_eight_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.divFuse && coreTick |=> !coreTick [*7])
        else $error("Divided core tick too frequent");
    wdt_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        watchdogTick |=> watchdogTickOut)
        else $error("Watchdog tick lost");

    // ==========================================
    // Sequencing and bus checks
    osc14_target_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_OSC14 |-> cntTarget == RESET_OSC_CK)
        else $error("Oscillator start count wrong");
    delay_wdt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_DELAY && !cntDone && !watchdogTick |=> st_r.phase == PH_DELAY)
        else $error("Reset delay left without watchdog tick");
    lf_short_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_WAKE && st_r.src == OSC_LFXTAL && !st_r.lenFuse |-> cntTarget == WAKE_LF_SHORT_CK)
        else $error("Crystal short wake count wrong");
    source_rc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_CAPTURE && clockSourceSelectFuses == SRC_RC ##1 st_r.phase != PH_CAPTURE
        |-> oscSelect == OSC_RC)
        else $error("RC source decode wrong");
    undivided_tick_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !st_r.divFuse && st_r.phase == PH_RUN && selTick |=> coreTick)
        else $error("Undivided core tick missing");
    core_tick_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        coreTick |-> $past(st_r.phase) == PH_RUN)
        else $error("Core tick outside run phase");
    sleep_closes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_RUN && sleepReq |=> !clockGateOpen)
        else $error("Clock still open after sleep");
    run_holds_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_RUN && !sleepReq |=> clockGateOpen)
        else $error("Clock closed without sleep");
    sleep_holds_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_SLEEP && !wakeReq |=> st_r.phase == PH_SLEEP)
        else $error("Sleep left without wake");
    wake_closed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_SLEEP && wakeReq |=> st_r.phase == PH_WAKE && !clockGateOpen)
        else $error("Wake count not started");
    halt_holds_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase == PH_HALT |=> st_r.phase == PH_HALT)
        else $error("Halt left before reset");
    trim_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_r.phase != PH_CAPTURE && !(regWr && regAddr == TRIM_ADDR) |=> $stable(oscillatorTrimRegister))
        else $error("Trim changed without write");
    trim_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regRd && regAddr == TRIM_ADDR |=> regRdata == $past(oscillatorTrimRegister))
        else $error("Trim read data wrong");
endmodule

//--- src/clock_startup_pkg.sv
package clock_startup_pkg;
    // ==========================================
    // Widths
    localparam int CNT_W = 24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ==========================================
    // Register map
    localparam logic [ADDR_W-1:0] TRIM_ADDR = 8'h66;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h67;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_HALT_BIT = 1;
    localparam int STAT_SLEEP_BIT = 2;
    localparam int STAT_DIV_BIT = 3;

    // ==========================================
    // Fuse encodings
    localparam logic [3:0] SRC_RC = 4'h2;
    localparam logic [3:0] SRC_LP128 = 4'h3;
    localparam logic [2:0] SRC_LFXTAL_HI = 3'h2;
    localparam logic [1:0] SUT_NONE = 2'h0;
    localparam logic [1:0] SUT_FAST = 2'h1;
    localparam logic [1:0] SUT_SLOW = 2'h2;
    localparam logic [1:0] SUT_RSVD = 2'h3;

    // ==========================================
    // Shipped fuse values
    localparam logic [3:0] SRC_SHIPPED = SRC_RC;
    localparam logic [1:0] SUT_SHIPPED = SUT_SLOW;
    localparam logic DIV8_SHIPPED = 1'b1;
    localparam logic LEN_SHIPPED = 1'b0;
    localparam logic [DATA_W-1:0] TRIM_RESET = 8'h80;

    // ==========================================
    // Oscillator cycle counts
    localparam logic [CNT_W-1:0] RESET_OSC_CK = 24'h00000E;
    localparam logic [CNT_W-1:0] WAKE_LF_SHORT_CK = 24'h000400;
    localparam logic [CNT_W-1:0] WAKE_LF_LONG_CK = 24'h008000;
    localparam logic [CNT_W-1:0] WAKE_INT_CK = 24'h000006;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // ==========================================
    // Reset time-out delays, in watchdog oscillator ticks
    localparam int WDT_TICKS_PER_MS = 100;
    localparam int DELAY_4P1MS_US = 4100;
    localparam int DELAY_65MS_US = 65000;
    localparam int DELAY_4MS_US = 4000;
    localparam int DELAY_64MS_US = 64000;
    localparam int CYC_4P1MS = DELAY_4P1MS_US * WDT_TICKS_PER_MS / 1000;
    localparam int CYC_65MS = DELAY_65MS_US * WDT_TICKS_PER_MS / 1000;
    localparam int CYC_4MS = DELAY_4MS_US * WDT_TICKS_PER_MS / 1000;
    localparam int CYC_64MS = DELAY_64MS_US * WDT_TICKS_PER_MS / 1000;

    // ==========================================
    // Oscillator selection and phases
    typedef enum logic [1:0] {OSC_NONE, OSC_LFXTAL, OSC_RC, OSC_LP128} osc_sel_t;
    typedef enum logic [2:0] {PH_CAPTURE, PH_OSC14, PH_DELAY, PH_RUN, PH_SLEEP, PH_WAKE, PH_HALT} phase_t;

    function automatic logic [CNT_W-1:0] wakeCycles(input osc_sel_t src, input logic lenFuse);
        if (src == OSC_LFXTAL) begin
            wakeCycles = lenFuse ? WAKE_LF_LONG_CK : WAKE_LF_SHORT_CK;
        end else begin
            wakeCycles = WAKE_INT_CK;
        end
    endfunction

    function automatic osc_sel_t decodeSource(input logic [3:0] fuses);
        if (fuses == SRC_RC) begin
            decodeSource = OSC_RC;
        end else if (fuses == SRC_LP128) begin
            decodeSource = OSC_LP128;
        end else if (fuses[3:1] == SRC_LFXTAL_HI) begin
            decodeSource = OSC_LFXTAL;
        end else begin
            decodeSource = OSC_NONE;
        end
    endfunction
endpackage

//--- src/osc_cycle_counter.sv
`timescale 1ns/100ps
module osc_cycle_counter
    import clock_startup_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic advance,
    input wire logic [CNT_W-1:0] target,
    output logic done
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } cnt_state_t;

    cnt_state_t st_r;
    cnt_state_t st_nxt;

    assign done = (st_r.count == target);

    // ==========================================
    // Counter
    always_comb begin
        st_nxt = st_r;
        if (clear) begin
            st_nxt.count = '0;
        end else if (advance && !done) begin
            st_nxt.count = st_r.count + 24'h000001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    count_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clear && !done |=> st_r.count <= target)
        else $error("Start-up counter passed its target");
endmodule

//--- sim/clock_source_startup_select_tb.sv
`timescale 1ns/100ps
module clock_source_startup_select_tb
    import clock_startup_pkg::*;
;
    // ==========================================
    // Shortened reset delays
    localparam int D41 = 20;
    localparam int D65 = 50;
    localparam int D4 = 16;
    localparam int D64 = 40;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] srcFuses = SRC_SHIPPED;
    logic lenFuse = LEN_SHIPPED;
    logic [1:0] sutFuses = SUT_SHIPPED;
    logic div8Fuse = DIV8_SHIPPED;
    logic [7:0] factoryTrim = 8'h3C;
    logic lfXtalTick = 1'b0;
    logic rcTick = 1'b0;
    logic lp128Tick = 1'b0;
    logic watchdogTick = 1'b0;
    logic sleepReq = 1'b0;
    logic wakeReq = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic [7:0] trimOut;
    logic [1:0] oscSelect;
    logic clockGateOpen;
    logic coreTick;
    logic watchdogTickOut;
    logic wdLast = 1'b0;
    logic wdWatch = 1'b0;
    int tickPer = 1;
    int divCnt = 0;
    int cyc = 0;
    int nMismatch = 0;
    int nChecks = 0;

    clock_source_startup_select #(.CYC_DELAY_4P1MS(D41), .CYC_DELAY_65MS(D65), .CYC_DELAY_4MS(D4),
        .CYC_DELAY_64MS(D64)) clock_source_startup_select_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .clockSourceSelectFuses(srcFuses),
        .startupLengthSelectFuse(lenFuse), .startupTimeFuses(sutFuses), .divideByEightFuse(div8Fuse),
        .factoryTrim(factoryTrim), .lfXtalTick(lfXtalTick), .rcTick(rcTick), .lp128Tick(lp128Tick),
        .watchdogTick(watchdogTick), .sleepReq(sleepReq), .wakeReq(wakeReq), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .oscillatorTrimRegister(trimOut), .oscSelect(oscSelect), .clockGateOpen(clockGateOpen),
        .coreTick(coreTick), .watchdogTickOut(watchdogTickOut));

    // ==========================================
    // Clock, oscillator ticks, timeout
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        divCnt <= (!rst_n || divCnt >= tickPer - 1) ? 0 : divCnt + 1;
        lfXtalTick <= (srcFuses[3:1] == 3'h2) ? (divCnt == 0) : 1'b1;
        rcTick <= (srcFuses == SRC_RC) ? (divCnt == 0) : 1'b1;
        lp128Tick <= (srcFuses == SRC_LP128) ? (divCnt == 0) : 1'b1;
        watchdogTick <= rst_n ? ~watchdogTick : 1'b0;
        wdLast <= watchdogTick;
        if (cyc >= 60000) begin
            nMismatch++;
            giveVerdict();
        end
    end

    always @(negedge sys_clk) begin
        if (wdWatch) begin
            chkVal(watchdogTickOut, wdLast);
        end
    end

    // ==========================================
    // Compare and bus tasks
    task automatic chkVal(input logic [23:0] got, input logic [23:0] exp);
        nChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: value %0h, expected %0h", $time, got, exp);
        end
    endtask

    task automatic chkSpan(input int n, input int lo, input int hi);
        nChecks++;
        if (n < lo || n > hi) begin
            nMismatch++;
            $display("Error at %0t: span %0d outside %0d..%0d", $time, n, lo, hi);
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic regRead(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chkVal(regRdata, exp);
    endtask

    task automatic startRun(input logic [3:0] src, input logic [1:0] startup_time_fuses, input int per, output int n);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        srcFuses <= src;
        sutFuses <= startup_time_fuses;
        tickPer <= per;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (clockGateOpen !== 1'b1 && n < 300);
    endtask

    task automatic wakeRun(output int n);
        @(posedge sys_clk);
        sleepReq <= 1'b1;
        @(posedge sys_clk);
        sleepReq <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chkVal(clockGateOpen, 1'b0);
        regRead(STATUS_ADDR, 8'h04);
        @(posedge sys_clk);
        wakeReq <= 1'b1;
        @(posedge sys_clk);
        wakeReq <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (clockGateOpen !== 1'b1 && n < 40000);
    endtask

    // ==========================================
    // Scenarios
    task automatic testStartup(input logic [3:0] src, input logic [1:0] sel, input int dA, input int dB);
        int n0;
        int n1;
        int n2;
        startRun(src, SUT_NONE, 1, n0);
        chkSpan(n0, 15, 20);
        chkVal(oscSelect, sel);
        startRun(src, SUT_FAST, 1, n1);
        chkSpan(n1 - n0, 2 * dA + 1, 2 * dA + 2);
        startRun(src, SUT_SLOW, 1, n2);
        chkSpan(n2 - n1, 2 * (dB - dA), 2 * (dB - dA));
        startRun(src, SUT_NONE, 3, n1);
        chkSpan(n1 - n0, 26, 30);
        startRun(src, SUT_RSVD, 1, n1);
        chkSpan(n1, 300, 300);
        regRead(STATUS_ADDR, 8'h0A);
    endtask

    task automatic testWake();
        int n;
        startRun(SRC_RC, SUT_NONE, 1, n);
        wakeRun(n);
        chkSpan(n, 6, 10);
        lenFuse <= 1'b0;
        startRun(4'h4, SUT_NONE, 1, n);
        wakeRun(n);
        chkSpan(n, 1024, 1028);
        lenFuse <= 1'b1;
        startRun(4'h5, SUT_NONE, 1, n);
        wakeRun(n);
        chkSpan(n, 32768, 32772);
    endtask

    task automatic testTrim();
        int n;
        factoryTrim <= 8'h3C;
        startRun(SRC_RC, SUT_NONE, 1, n);
        chkVal(trimOut, 8'h3C);
        regRead(TRIM_ADDR, 8'h3C);
        regWrite(TRIM_ADDR, 8'hA5);
        chkVal(trimOut, 8'hA5);
        regRead(TRIM_ADDR, 8'hA5);
        regRead(8'h10, 8'h00);
        regRead(STATUS_ADDR, 8'h09);
        factoryTrim <= 8'hC3;
        startRun(SRC_LP128, SUT_NONE, 1, n);
        chkVal(trimOut, 8'hC3);
    endtask

    task automatic testDivide(input logic div, input int lo, input int hi);
        int n;
        int k;
        div8Fuse <= div;
        startRun(SRC_LP128, SUT_NONE, 1, n);
        wdWatch <= 1'b1;
        k = 0;
        repeat (160) begin
            @(posedge sys_clk);
            #1;
            if (coreTick === 1'b1) begin
                k++;
            end
        end
        wdWatch <= 1'b0;
        chkSpan(k, lo, hi);
    endtask

    task automatic giveVerdict();
        $display("Mismatches: %0d, checks: %0d", nMismatch, nChecks);
        if (nMismatch == 0 && nChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        chkVal(SRC_SHIPPED, 4'h2);
        chkVal(SUT_SHIPPED, 2'h2);
        chkVal(DIV8_SHIPPED, 1'b1);
        testStartup(SRC_RC, 2'h2, D41, D65);
        testStartup(SRC_LP128, 2'h3, D4, D64);
        testStartup(4'h4, 2'h1, D41, D65);
        testTrim();
        testDivide(1'b1, 19, 21);
        testDivide(1'b0, 159, 161);
        testWake();
        giveVerdict();
    end
endmodule
